// *** src/gpio_port_pkg.sv ***
// package for the six-pin general purpose port: register map, field layout,
// reset values and timing figures.
// assumes a single 20 MHz system clock and 32-bit AXI4-Lite register access.
package gpio_port_pkg;

   // ---------------------------------------------------------------
   // sizes
   // ---------------------------------------------------------------
   localparam int PIN_COUNT = 6;
   localparam int ADDR_W    = 12;
   localparam int DATA_W    = 32;
   localparam int STRB_W    = DATA_W / 8;
   localparam int HOLD_W    = 2;

   // ---------------------------------------------------------------
   // register byte addresses
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] SYS_IRQ_STATUS_OFS        = 12'h058;
   localparam logic [ADDR_W-1:0] SYS_IRQ_ENABLE_OFS        = 12'h05c;
   localparam logic [ADDR_W-1:0] PIN_CONFIG_OFS            = 12'h1e0;
   localparam logic [ADDR_W-1:0] PIN_DATA_DIRECTION_OFS    = 12'h1e4;
   localparam logic [ADDR_W-1:0] PIN_IRQ_STATUS_ENABLE_OFS = 12'h1e8;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int LOW_FIELD_LSB  = 0;
   localparam int HIGH_FIELD_LSB = 16;
   localparam int PIN_EVENT_BIT  = 12;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [PIN_COUNT-1:0] DIRECTION_RST = 6'h00;
   localparam logic [PIN_COUNT-1:0] DATA_RST      = 6'h00;
   localparam logic [PIN_COUNT-1:0] POLARITY_RST  = 6'h00;
   localparam logic [PIN_COUNT-1:0] BUFFER_RST    = 6'h00;
   localparam logic [PIN_COUNT-1:0] IRQ_EN_RST    = 6'h00;
   localparam logic [PIN_COUNT-1:0] IRQ_STS_RST   = 6'h00;
   localparam logic                 SYS_EN_RST    = 1'b0;

   // ---------------------------------------------------------------
   // bus answers
   // ---------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int PULSE_MIN_NS  = 40;
   // least time: round up, never below one cycle
   localparam int PULSE_MIN_CYC_RAW = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_MIN_CYC     = (PULSE_MIN_CYC_RAW < 1) ? 1 : PULSE_MIN_CYC_RAW;

endpackage

// *** src/pin_sync_if.sv ***
// interface between the pin synchroniser and the port logic.
// assumes raw pin levels may change at any time relative to aclk.
`timescale 1ns/1ns
interface pin_sync_if #(
   parameter int N = 6
);
   logic [N-1:0] raw;
   logic [N-1:0] level;

   modport sync (
      input  raw,
      output level
   );
   modport user (
      output raw,
      input  level
   );
endinterface

// *** src/pin_sync.sv ***
// two-flop synchroniser for the pin inputs.
// assumes aclk and a synchronous active-low reset.
`timescale 1ns/1ns
module pin_sync #(
   parameter int N = 6
) (
   input  wire logic   aclk,
   input  wire logic   aresetn,
   pin_sync_if.sync    pins
);

   typedef struct packed {
      logic [N-1:0] meta;
      logic [N-1:0] level;
   } sync_s;

   sync_s st_q;
   sync_s st_d;

   // ---------------------------------------------------------------
   // stages
   // ---------------------------------------------------------------
   // meta feeds only the second stage
   always_comb begin
      st_d       = st_q;
      st_d.meta  = pins.raw;
      st_d.level = st_q.meta;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign pins.level = st_q.level;

endmodule

// *** src/general_purpose_pin_port.sv ***
// six-pin general purpose port with per-pin direction, output data,
// open-drain or push-pull drive, level interrupts and a summary event.
// assumes an AXI4-Lite master on aclk; pins are sampled through pin_sync.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// Contract
// - direction bit one is output, resets input
// - output pins drive last written data
// - input pin reads return sampled level
// - output pin reads return written value
// - write one clears status, zero keeps
// - enabled statuses OR into group event
// - status records regardless of pin enable
// - pin enable adds status to event
// - irq needs group enable also set
// - level detection, hold over 40 ns
// - trigger level from per-pin polarity
// - polarity zero low, one high trigger
// - buffer zero is open drain drive
// - group event bit twelve read-only
module general_purpose_pin_port #(
   parameter int N = gpio_port_pkg::PIN_COUNT
) (
   input  wire logic                              aclk,
   input  wire logic                              aresetn,
   input  wire logic [gpio_port_pkg::ADDR_W-1:0]  awaddr,
   input  wire logic                              awvalid,
   output wire logic                              awready,
   input  wire logic [gpio_port_pkg::DATA_W-1:0]  wdata,
   input  wire logic [gpio_port_pkg::STRB_W-1:0]  wstrb,
   input  wire logic                              wvalid,
   output wire logic                              wready,
   output wire logic [1:0]                        bresp,
   output wire logic                              bvalid,
   input  wire logic                              bready,
   input  wire logic [gpio_port_pkg::ADDR_W-1:0]  araddr,
   input  wire logic                              arvalid,
   output wire logic                              arready,
   output wire logic [gpio_port_pkg::DATA_W-1:0]  rdata,
   output wire logic [1:0]                        rresp,
   output wire logic                              rvalid,
   input  wire logic                              rready,
   input  wire logic [N-1:0]                      pin_in,
   output wire logic [N-1:0]                      pin_out,
   output wire logic [N-1:0]                      pin_oe,
   output wire logic                              irq
);

   localparam int AW = gpio_port_pkg::ADDR_W;
   localparam int DW = gpio_port_pkg::DATA_W;
   localparam int SW = gpio_port_pkg::STRB_W;
   localparam int HW = gpio_port_pkg::HOLD_W;
   localparam int LO = gpio_port_pkg::LOW_FIELD_LSB;
   localparam int HI = gpio_port_pkg::HIGH_FIELD_LSB;
   localparam logic [HW-1:0] HOLD_TARGET = HW'(gpio_port_pkg::PULSE_MIN_CYC - 1);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [N-1:0]          direction;
      logic [N-1:0]          data;
      logic [N-1:0]          polarity;
      logic [N-1:0]          buffer_type;
      logic [N-1:0]          irq_enable;
      logic [N-1:0]          irq_status;
      logic                  sys_enable;
      logic [N-1:0][HW-1:0]  hold;
      logic                  aw_held;
      logic [AW-1:0]         aw_addr;
      logic                  w_held;
      logic [DW-1:0]         w_data;
      logic [SW-1:0]         w_strb;
      logic                  b_valid;
      logic [1:0]            b_resp;
      logic                  r_valid;
      logic [DW-1:0]         r_data;
      logic [1:0]            r_resp;
      logic [N-1:0]          pin_out;
      logic [N-1:0]          pin_oe;
      logic                  irq;
   } port_s;

   typedef enum {
      SEL_NONE,
      SEL_SYS_STATUS,
      SEL_SYS_ENABLE,
      SEL_CONFIG,
      SEL_DATA_DIR,
      SEL_IRQ_STS_EN
   } reg_sel_e;

   port_s st_q;
   port_s st_d;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic reg_sel_e decode(input logic [AW-1:0] addr);
      reg_sel_e sel;
      sel = SEL_NONE;
      case ({addr[AW-1:2], 2'h0})
         gpio_port_pkg::SYS_IRQ_STATUS_OFS:        sel = SEL_SYS_STATUS;
         gpio_port_pkg::SYS_IRQ_ENABLE_OFS:        sel = SEL_SYS_ENABLE;
         gpio_port_pkg::PIN_CONFIG_OFS:            sel = SEL_CONFIG;
         gpio_port_pkg::PIN_DATA_DIRECTION_OFS:    sel = SEL_DATA_DIR;
         gpio_port_pkg::PIN_IRQ_STATUS_ENABLE_OFS: sel = SEL_IRQ_STS_EN;
         default:                                  sel = SEL_NONE;
      endcase
      return sel;
   endfunction

   function automatic logic [DW-1:0] lane_mask(input logic [SW-1:0] strb);
      logic [DW-1:0] m;
      m = '0;
      for (int b = 0; b < SW; b++) begin
         m[b*8 +: 8] = {8{strb[b]}};
      end
      return m;
   endfunction

   // places a low and a high pin field into one register word
   function automatic logic [DW-1:0] pack_fields(input logic [N-1:0] low_f,
                                                 input logic [N-1:0] high_f);
      logic [DW-1:0] w;
      w = '0;
      w[LO +: N] = low_f;
      w[HI +: N] = high_f;
      return w;
   endfunction

   // ---------------------------------------------------------------
   // pin synchroniser
   // ---------------------------------------------------------------
   pin_sync_if #(.N(N)) sync_bus ();

   assign sync_bus.raw = pin_in;

   pin_sync #(
      .N (N)
   ) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pins    (sync_bus)
   );

   // ---------------------------------------------------------------
   // combinational view
   // ---------------------------------------------------------------
   logic [N-1:0] pin_level;
   logic [N-1:0] trigger;
   logic [N-1:0] qualified;
   logic [N-1:0] readback;
   logic         group_event;

   assign pin_level   = sync_bus.level;
   // polarity zero watches for low, one for high
   assign trigger     = ~(pin_level ^ st_q.polarity);
   assign readback    = (st_q.direction & st_q.data)
                      | (~st_q.direction & pin_level);
   assign group_event = |(st_q.irq_status & st_q.irq_enable);

   // level must be seen for the least hold time before it counts
   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_qual
         assign qualified[gi] = trigger[gi] && (st_q.hold[gi] == HOLD_TARGET);
      end
   endgenerate

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   logic              aw_take;
   logic              w_take;
   logic              ar_take;
   logic              have_aw;
   logic              have_w;
   logic [AW-1:0]     wr_addr;
   logic [DW-1:0]     wr_data;
   logic [DW-1:0]     wr_mask;
   logic [DW-1:0]     wr_old;
   logic [DW-1:0]     wr_new;
   logic [N-1:0]      clear_bits;
   logic [DW-1:0]     rd_word;
   reg_sel_e          wr_sel;
   reg_sel_e          rd_sel;

   assign awready = !st_q.aw_held && !st_q.b_valid;
   assign wready  = !st_q.w_held && !st_q.b_valid;
   assign arready = !st_q.r_valid;

   always_comb begin
      st_d       = st_q;
      aw_take    = awvalid && awready;
      w_take     = wvalid && wready;
      ar_take    = arvalid && arready;
      have_aw    = st_q.aw_held || aw_take;
      have_w     = st_q.w_held || w_take;
      wr_addr    = st_q.aw_held ? st_q.aw_addr : awaddr;
      wr_data    = st_q.w_held ? st_q.w_data : wdata;
      wr_mask    = lane_mask(st_q.w_held ? st_q.w_strb : wstrb);
      wr_sel     = decode(wr_addr);
      rd_sel     = decode(araddr);
      wr_old     = '0;
      wr_new     = '0;
      clear_bits = '0;
      rd_word    = '0;

      // write address and data may arrive in either order
      if (aw_take) begin
         st_d.aw_held = 1'b1;
         st_d.aw_addr = awaddr;
      end
      if (w_take) begin
         st_d.w_held = 1'b1;
         st_d.w_data = wdata;
         st_d.w_strb = wstrb;
      end

      // --- register writes, once both halves are present
      if (have_aw && have_w) begin
         st_d.aw_held = 1'b0;
         st_d.w_held  = 1'b0;
         st_d.b_valid = 1'b1;
         st_d.b_resp  = gpio_port_pkg::RESP_OKAY;
         case (wr_sel)
            SEL_SYS_STATUS: begin
               // event bit is a summary only, writes have no effect
            end
            SEL_SYS_ENABLE: begin
               if (wr_mask[gpio_port_pkg::PIN_EVENT_BIT]) begin
                  st_d.sys_enable = wr_data[gpio_port_pkg::PIN_EVENT_BIT];
               end
            end
            SEL_CONFIG: begin
               wr_old = pack_fields(st_q.buffer_type, st_q.polarity);
               wr_new = (wr_old & ~wr_mask) | (wr_data & wr_mask);
               st_d.buffer_type = wr_new[LO +: N];
               st_d.polarity    = wr_new[HI +: N];
            end
            SEL_DATA_DIR: begin
               // merge against stored data, not the read-back view
               wr_old = pack_fields(st_q.data, st_q.direction);
               wr_new = (wr_old & ~wr_mask) | (wr_data & wr_mask);
               st_d.data      = wr_new[LO +: N];
               st_d.direction = wr_new[HI +: N];
            end
            SEL_IRQ_STS_EN: begin
               wr_old = pack_fields('0, st_q.irq_enable);
               wr_new = (wr_old & ~wr_mask) | (wr_data & wr_mask);
               st_d.irq_enable = wr_new[HI +: N];
               clear_bits      = wr_data[LO +: N] & wr_mask[LO +: N];
            end
            default: begin
               st_d.b_resp = gpio_port_pkg::RESP_SLVERR;
            end
         endcase
      end

      if (st_q.b_valid && bready) begin
         st_d.b_valid = 1'b0;
      end

      // --- register reads
      case (rd_sel)
         SEL_SYS_STATUS: begin
            rd_word[gpio_port_pkg::PIN_EVENT_BIT] = group_event;
         end
         SEL_SYS_ENABLE: begin
            rd_word[gpio_port_pkg::PIN_EVENT_BIT] = st_q.sys_enable;
         end
         SEL_CONFIG: begin
            rd_word = pack_fields(st_q.buffer_type, st_q.polarity);
         end
         SEL_DATA_DIR: begin
            rd_word = pack_fields(readback, st_q.direction);
         end
         SEL_IRQ_STS_EN: begin
            rd_word = pack_fields(st_q.irq_status, st_q.irq_enable);
         end
         default: begin
            rd_word = '0;
         end
      endcase
      if (ar_take) begin
         st_d.r_valid = 1'b1;
         st_d.r_data  = rd_word;
         st_d.r_resp  = (rd_sel == SEL_NONE) ? gpio_port_pkg::RESP_SLVERR
                                             : gpio_port_pkg::RESP_OKAY;
      end else if (st_q.r_valid && rready) begin
         st_d.r_valid = 1'b0;
      end

      // --- level detection, one hold counter per pin
      for (int i = 0; i < N; i++) begin
         if (!trigger[i]) begin
            st_d.hold[i] = '0;
         end else if (st_q.hold[i] != HOLD_TARGET) begin
            st_d.hold[i] = st_q.hold[i] + HW'(1);
         end
      end

      // status records independent of enables; set beats clear
      st_d.irq_status = (st_q.irq_status & ~clear_bits) | qualified;

      // --- pin drive, from the values about to be stored
      // open drain: only a zero is driven, a one floats
      st_d.pin_oe  = st_d.direction & (st_d.buffer_type | ~st_d.data);
      st_d.pin_out = st_d.data;

      // --- interrupt request, gated by the group enable
      st_d.irq = (|(st_d.irq_status & st_d.irq_enable)) && st_d.sys_enable;
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q             <= '0;
         st_q.direction   <= gpio_port_pkg::DIRECTION_RST;
         st_q.data        <= gpio_port_pkg::DATA_RST;
         st_q.polarity    <= gpio_port_pkg::POLARITY_RST;
         st_q.buffer_type <= gpio_port_pkg::BUFFER_RST;
         st_q.irq_enable  <= gpio_port_pkg::IRQ_EN_RST;
         st_q.irq_status  <= gpio_port_pkg::IRQ_STS_RST;
         st_q.sys_enable  <= gpio_port_pkg::SYS_EN_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign bvalid  = st_q.b_valid;
   assign bresp   = st_q.b_resp;
   assign rvalid  = st_q.r_valid;
   assign rdata   = st_q.r_data;
   assign rresp   = st_q.r_resp;
   assign pin_out = st_q.pin_out;
   assign pin_oe  = st_q.pin_oe;
   assign irq     = st_q.irq;

endmodule

// *** tb/pin_board.sv ***
// board side of the six pins: pull-ups plus an optional external driver.
// assumes the device drives a pin only while its enable is high.
`timescale 1ns/1ns
module pin_board #(
   parameter int N = 6
) (
   input  wire logic [N-1:0] pin_out,
   input  wire logic [N-1:0] pin_oe,
   input  wire logic [N-1:0] ext_en,
   input  wire logic [N-1:0] ext_val,
   output wire logic [N-1:0] pin_level
);
   // ----------------
   // wire level
   // ----------------
   // released pins follow ext_val where ext_en is set, else the pull-up, so undriven open drain high reads as one
   assign pin_level = (pin_oe & pin_out) | (~pin_oe & ~ext_en) | (~pin_oe & ext_en & ext_val);
endmodule

// *** tb/general_purpose_pin_port_assertions.sv ***
// checker for the six-pin port, bound to its top module.
// assumes aligned word accesses and a single aclk domain.
`timescale 1ns/1ns
module pin_port_checker #(
   parameter int N = 6
) (
   input wire logic         aclk,
   input wire logic         aresetn,
   input wire logic         awvalid,
   input wire logic         awready,
   input wire logic         wvalid,
   input wire logic         wready,
   input wire logic         bvalid,
   input wire logic [11:0]  araddr,
   input wire logic         arvalid,
   input wire logic         arready,
   input wire logic [31:0]  rdata,
   input wire logic [1:0]   rresp,
   input wire logic         rvalid,
   input wire logic [N-1:0] pin_in,
   input wire logic [N-1:0] pin_out,
   input wire logic [N-1:0] pin_oe,
   input wire logic         irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ----------------
   // pin calm counter
   // ----------------
   // read-back of inputs is only judged once the pins sat still
   logic [N-1:0] prev_q;
   logic [1:0]   calm_q;
   wire          rd_take = arvalid && arready;

   always_ff @(posedge aclk) begin
      prev_q <= pin_in;
      if (!aresetn || pin_in != prev_q) begin
         calm_q <= 2'h0;
      end else if (calm_q != 2'h3) begin
         calm_q <= calm_q + 2'h1;
      end
   end

   // ----------------
   // properties
   // ----------------
   a_write_answer: assert property (awvalid && awready && wvalid && wready |=> bvalid)
      else $error("write taken without answer");
   a_read_answer: assert property (rd_take |=> rvalid)
      else $error("read taken without answer");
   a_write_busy: assert property (bvalid |-> !awready && !wready)
      else $error("write channels open while answer pending");
   a_read_busy: assert property (rvalid |-> !arready)
      else $error("read channel open while answer pending");
   a_unmapped_error: assert property (rd_take && araddr[1:0] == 2'h0
      && !(araddr inside {12'h058, 12'h05c, 12'h1e0, 12'h1e4, 12'h1e8}) |=> rresp == 2'h2 && rdata == 32'h0)
      else $error("unmapped read not refused");
   a_pins_on_write: assert property (!$stable(pin_oe) || !$stable(pin_out) |-> $rose(bvalid))
      else $error("pin drive changed without a write");
   a_readback_output: assert property (rd_take && araddr == 12'h1e4 |=>
      ((rdata[5:0] ^ $past(pin_out)) & rdata[21:16]) == 6'h0)
      else $error("output pin read-back differs from stored data");
   a_readback_input: assert property (rd_take && araddr == 12'h1e4 && calm_q == 2'h3 && pin_in == prev_q |=>
      ((rdata[5:0] ^ $past(pin_in)) & ~rdata[21:16]) == 6'h0)
      else $error("input pin read-back differs from pin level");

   c_irq_raised: cover property ($rose(irq));
   c_unmapped: cover property (rd_take ##1 rresp == 2'h2);
   c_oe_change: cover property (!$stable(pin_oe));
endmodule

bind general_purpose_pin_port pin_port_checker #(.N(N)) u_pin_port_checker (
   .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
   .wready(wready), .bvalid(bvalid), .araddr(araddr), .arvalid(arvalid), .arready(arready),
   .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .pin_in(pin_in), .pin_out(pin_out),
   .pin_oe(pin_oe), .irq(irq)
);

// *** tb/general_purpose_pin_port_bench.sv ***
// bench for the six-pin port: bus tasks, board model, scripted checks.
// assumes the checker binds itself and aclk runs at 20 MHz.
`timescale 1ns/1ns
module general_purpose_pin_port_bench;
   localparam logic [11:0] SYS_A = gpio_port_pkg::SYS_IRQ_STATUS_OFS;
   localparam logic [11:0] SEN_A = gpio_port_pkg::SYS_IRQ_ENABLE_OFS;
   localparam logic [11:0] CFG_A = gpio_port_pkg::PIN_CONFIG_OFS;
   localparam logic [11:0] DIR_A = gpio_port_pkg::PIN_DATA_DIRECTION_OFS;
   localparam logic [11:0] STS_A = gpio_port_pkg::PIN_IRQ_STATUS_ENABLE_OFS;
   logic             aclk = 1'b0;
   logic             aresetn = 1'b0;
   logic [11:0]      awaddr = 12'h0;
   logic [11:0]      araddr = 12'h0;
   logic [31:0]      wdata = 32'h0;
   logic [3:0]       wstrb = 4'h0;
   logic             awvalid = 1'b0;
   logic             wvalid = 1'b0;
   logic             bready = 1'b0;
   logic             arvalid = 1'b0;
   logic             rready = 1'b0;
   logic [5:0]       ext_en = 6'h0;
   logic [5:0]       ext_val = 6'h0;
   logic [1:0]       rsp;
   int               err_total = 0;
   int               checks_done = 0;
   wire logic        awready, wready, bvalid, arready, rvalid, irq;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [5:0]  pin_in, pin_out, pin_oe;

   initial begin
      forever #25 aclk = ~aclk;
   end

   general_purpose_pin_port u_general_purpose_pin_port (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq)
   );

   pin_board u_pin_board (
      .pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_in)
   );

   // ----------------
   // tasks
   // ----------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
      bit ta;
      bit tw;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      ta = 1'b0;
      tw = 1'b0;
      while (!(ta && tw)) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            ta = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            tw = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      rsp = bresp;
      bready <= 1'b0;
   endtask

   task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er = 2'h0);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!(arvalid && arready));
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk($sformatf("rdata_%h", a), e, rdata & m);
      chk("rresp", 32'(er), 32'(rresp));
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ----------------
   // sequence
   // ----------------
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      // synchroniser needs its flush before pins read true
      repeat (3) @(posedge aclk);
      rc(DIR_A, 32'h3f, '1);
      rc(STS_A, 32'h0, 32'h3f0000);
      rc(CFG_A, 32'h0, '1);
      rc(SEN_A, 32'h0, '1);
      wr(STS_A, 32'h3f);
      rc(STS_A, 32'h0, '1);
      ext_en <= 6'h3f;
      ext_val <= 6'h25;
      repeat (4) @(posedge aclk);
      rc(DIR_A, 32'h25, '1);
      rc(STS_A, 32'h1a, '1);
      wr(STS_A, 32'h0);
      rc(STS_A, 32'h1a, '1);
      wr(STS_A, 32'h2);
      rc(STS_A, 32'h1a, '1);
      ext_en <= 6'h0;
      repeat (4) @(posedge aclk);
      wr(STS_A, 32'h2);
      rc(STS_A, 32'h18, '1);
      // high trigger on pulled-up pins, then enables
      wr(CFG_A, 32'h3f003f);
      repeat (4) @(posedge aclk);
      rc(STS_A, 32'h3f, '1);
      rc(SYS_A, 32'h0, 32'h1000);
      wr(STS_A, 32'h10000);
      rc(SYS_A, 32'h1000, '1);
      chk("irq", 32'h0, 32'(irq));
      wr(SEN_A, 32'h1000);
      repeat (2) @(posedge aclk);
      chk("irq", 32'h1, 32'(irq));
      wr(SYS_A, 32'h0);
      rc(SYS_A, 32'h1000, '1);
      wr(STS_A, 32'h0);
      repeat (2) @(posedge aclk);
      chk("irq", 32'h0, 32'(irq));
      wr(STS_A, 32'h10000);
      wr(CFG_A, 32'h3f);
      wr(STS_A, 32'h10001);
      repeat (2) @(posedge aclk);
      chk("irq", 32'h0, 32'(irq));
      // drive: push-pull, then open drain with the board pulling released pin 0 low
      wr(DIR_A, 32'h3f0015);
      chk("pin_oe", 32'h3f, 32'(pin_oe));
      chk("pin_out", 32'h15, 32'(pin_out));
      rc(DIR_A, 32'h3f0015, '1);
      wr(CFG_A, 32'h0);
      chk("pin_oe", 32'h2a, 32'(pin_oe));
      wr(DIR_A, 32'h70015);
      chk("pin_oe", 32'h2, 32'(pin_oe));
      ext_en <= 6'h1;
      ext_val <= 6'h0;
      repeat (4) @(posedge aclk);
      rc(DIR_A, 32'h7003d, '1);
      // lane 2 only: enables change, unstrobed status lane is left alone
      wr(STS_A, 32'h3f003f, 4'h4);
      rc(STS_A, 32'h3f003f, '1);
      rc(12'h100, 32'h0, '1, gpio_port_pkg::RESP_SLVERR);
      wr(12'h104, 32'h1);
      chk("bresp", 32'(gpio_port_pkg::RESP_SLVERR), 32'(rsp));
      summarize();
   end

   initial begin
      repeat (5000) @(posedge aclk);
      err_total++;
      summarize();
   end
endmodule
